// *** hw/tdsa_fifo.sv ***
// Output FIFO with registered read stage
`timescale 1ns/100ps
`default_nettype none
module tdsa_fifo #(
    parameter int W = 32,
    parameter int D = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] level
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q;
    logic push, load;

    // Space and transfer strobes
    assign in_ready = (cnt_q < (AW+1)'(D));
    assign push = in_valid & in_ready;
    assign load = (cnt_q != '0) & (~out_valid | out_ready);
    assign level = cnt_q;

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (load) begin
                rp_q <= rp_q + 1'b1;
            end
            if (push && !load) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (load && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Registered read stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_data <= mem[rp_q];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** hw/tdsa_map.svh ***
// Register map, field positions, reset values and timing counts
//
// Functional notes
// - A scan direction switch completes in under one millisecond.
// - Multi-array rows are delayed by a direction-dependent fixed row amount.
// - Correction offsets follow the scan direction automatically, no host action.
// - Dual-array main-to-secondary offset takes one of two direction-selected values.
// - Main line one plus spacing offset matches secondary line one in HDR/high-well.
// - Spatial correction delay is disabled in single-array integration mode.
// - Super-resolution mode supplies row spacing so arrays align into one image.
// - Up to the full stage count of rows accumulate per column.
// - With the marker setting on, alignment markers overlay the output image.
// - Lower-magnification array pixels are stretched to the full sensor width.
// - Parallax-stretched arrays depend on viewing angle sign, not scan direction.
// - Scan direction comes from internal setting, input line or encoder motion.
`ifndef TDSA_MAP_SVH
`define TDSA_MAP_SVH

`define TDSA_A_CTRL 8'h00
`define TDSA_A_STAT 8'h04
`define TDSA_A_OVL_ROW 8'h08
`define TDSA_A_OVL_COL 8'h0c
`define TDSA_A_DLY_FWD 8'h10
`define TDSA_A_DLY_REV 8'h14
`define TDSA_A_STAGES 8'h18
`define TDSA_A_PLX 8'h1c
`define TDSA_A_LINE 8'h20

`define TDSA_CTRL_SRC 1:0
`define TDSA_CTRL_DIR 2
`define TDSA_CTRL_MODE 6:4
`define TDSA_CTRL_MARK 8
`define TDSA_CTRL_DARK 9
`define TDSA_CTRL_ANGNEG 10
`define TDSA_CTRL_PLXON 11

`define TDSA_RST_CTRL 12'h000
`define TDSA_RST_DLY_FWD 32'h0146_00a3
`define TDSA_RST_DLY_REV 32'h00c6_0063
`define TDSA_RST_OVL 32'h0000_0040
`define TDSA_STAGES_MAX 8'h80
`define TDSA_FULL_W 15'h2000
`define TDSA_PIX_MAX 12'hfff

`define TDSA_CLK_NS 8
`define TDSA_SWITCH_NS 1000000
`define TDSA_SWITCH_CYC ((`TDSA_SWITCH_NS - 1) / `TDSA_CLK_NS)

`endif

// *** hw/tdsa_pkg.sv ***
// Types shared by the scan direction and line alignment block
package tdsa_pkg;
    typedef enum logic [2:0] {
        MODE_SINGLE = 3'b000,
        MODE_HDR = 3'b001,
        MODE_HIGH_WELL = 3'b010,
        MODE_TRIPLE = 3'b011,
        MODE_SR = 3'b100
    } tdsa_mode_e;
    typedef enum logic [1:0] {
        SRC_INT = 2'b00,
        SRC_LINE = 2'b01,
        SRC_ENC = 2'b10
    } tdsa_src_e;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SWITCH = 2'b01,
        ST_ARM = 2'b10
    } tdsa_state_e;
    typedef logic [15:0] tdsa_row_t;
endpackage

// *** hw/tdsa_top.sv ***
// Scan direction control, line alignment stamps, markers and parallax stretch
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "tdsa_map.svh"
module tdsa_top #(
    parameter int SWITCH_CYC = `TDSA_SWITCH_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic gpio_dir_line,
    input wire logic enc_dir_motion,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic pix_sol,
    input wire logic [1:0] pix_plane,
    input wire logic [11:0] pix_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [31:0] out_data,
    output logic scan_dir,
    output logic switch_busy
);
    import tdsa_pkg::*;

    // Software settings
    logic [11:0] ctrl_q;
    logic [31:0] ovl_row_q, ovl_col_q, dly_fwd_q, dly_rev_q;
    logic [7:0] stages_q;
    logic [14:0] plx_w_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic wr_en;

    // Direction control
    logic [1:0] sync1_q, sync2_q;
    tdsa_state_e st_q;
    logic [16:0] sw_cnt_q;
    logic dir_q, applied_q, want_dir, busy_q;

    // Data path
    tdsa_row_t line_q [3];
    tdsa_row_t off [3];
    logic [7:0] warm_q, warm_d;
    tdsa_row_t row_ph_q, col_ph_q, col_ph_cur;
    logic row_hit_q, row_hit, col_hit, mark;
    logic [14:0] acc_q, acc_cur, acc_sum, acc_d;
    logic [1:0] tgt;
    logic take, sol0, apply, sel, need_dup;
    logic push_v_q, dup_q, dup_d, pix_ready_q;
    logic [31:0] push_w_q, word;
    logic [11:0] val;
    tdsa_row_t stamp;
    logic fifo_in_ready;
    logic [5:0] level;
    tdsa_mode_e mode;

    // Advance a marker phase, reloading at zero
    function automatic tdsa_row_t ph_next(input tdsa_row_t ph, input tdsa_row_t pitch);
        ph_next = (ph == 16'h0000) ? pitch - 16'h0001 : ph - 16'h0001;
    endfunction

    assign mode = tdsa_mode_e'(ctrl_q[`TDSA_CTRL_MODE]);
    assign take = pix_valid & pix_ready_q;
    assign sol0 = take & pix_sol & (pix_plane == 2'b00);
    assign apply = (st_q == ST_ARM) & sol0;
    assign wr_en = psel & penable & pwrite & pready_q;

    // APB answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (psel && penable && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= 1'b0;
            case (paddr)
                `TDSA_A_CTRL: prdata_q <= {20'h00000, ctrl_q};
                `TDSA_A_STAT: prdata_q <= {22'h000000, level, st_q, applied_q, dir_q};
                `TDSA_A_OVL_ROW: prdata_q <= ovl_row_q;
                `TDSA_A_OVL_COL: prdata_q <= ovl_col_q;
                `TDSA_A_DLY_FWD: prdata_q <= dly_fwd_q;
                `TDSA_A_DLY_REV: prdata_q <= dly_rev_q;
                `TDSA_A_STAGES: prdata_q <= {24'h000000, stages_q};
                `TDSA_A_PLX: prdata_q <= {17'h00000, plx_w_q};
                `TDSA_A_LINE: prdata_q <= {8'h00, warm_q, line_q[0]};
                default: begin
                    prdata_q <= 32'h0000_0000;
                    pslverr_q <= 1'b1;
                end
            endcase
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Register writes take effect at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `TDSA_RST_CTRL;
            ovl_row_q <= `TDSA_RST_OVL;
            ovl_col_q <= `TDSA_RST_OVL;
            dly_fwd_q <= `TDSA_RST_DLY_FWD;
            dly_rev_q <= `TDSA_RST_DLY_REV;
            stages_q <= `TDSA_STAGES_MAX;
            plx_w_q <= `TDSA_FULL_W;
        end else if (wr_en) begin
            case (paddr)
                `TDSA_A_CTRL: ctrl_q <= pwdata[11:0];
                `TDSA_A_OVL_ROW: ovl_row_q <= pwdata;
                `TDSA_A_OVL_COL: ovl_col_q <= pwdata;
                `TDSA_A_DLY_FWD: dly_fwd_q <= pwdata;
                `TDSA_A_DLY_REV: dly_rev_q <= pwdata;
                `TDSA_A_STAGES: begin
                    if (pwdata[7:0] == 8'h00 || pwdata[7:0] > `TDSA_STAGES_MAX) begin
                        stages_q <= `TDSA_STAGES_MAX;
                    end else begin
                        stages_q <= pwdata[7:0];
                    end
                end
                `TDSA_A_PLX: begin
                    if (pwdata[14:0] == 15'h0000 || pwdata[14:0] > `TDSA_FULL_W) begin
                        plx_w_q <= `TDSA_FULL_W;
                    end else begin
                        plx_w_q <= pwdata[14:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Two-stage synchronisers for the direction pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 2'b00;
            sync2_q <= 2'b00;
        end else begin
            sync1_q <= {enc_dir_motion, gpio_dir_line};
            sync2_q <= sync1_q;
        end
    end

    // Direction source select
    always_comb begin
        case (tdsa_src_e'(ctrl_q[`TDSA_CTRL_SRC]))
            SRC_INT: want_dir = ctrl_q[`TDSA_CTRL_DIR];
            SRC_LINE: want_dir = sync2_q[0];
            SRC_ENC: want_dir = sync2_q[1];
            default: want_dir = ctrl_q[`TDSA_CTRL_DIR];
        endcase
    end

    // Direction switch sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_RUN;
            sw_cnt_q <= 17'h00000;
            dir_q <= 1'b0;
            applied_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            case (st_q)
                ST_RUN: begin
                    if (want_dir != dir_q) begin
                        st_q <= ST_SWITCH;
                        busy_q <= 1'b1;
                        sw_cnt_q <= 17'(SWITCH_CYC - 1);
                    end
                end
                ST_SWITCH: begin
                    if (sw_cnt_q == 17'h00000) begin
                        st_q <= ST_ARM;
                        dir_q <= ~dir_q;
                    end else begin
                        sw_cnt_q <= sw_cnt_q - 17'h00001;
                    end
                end
                ST_ARM: begin
                    if (sol0) begin
                        st_q <= ST_RUN;
                        applied_q <= dir_q;
                        busy_q <= 1'b0;
                    end
                end
                default: begin
                    st_q <= ST_RUN;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // Per-plane row offsets from the applied direction
    always_comb begin
        off[0] = 16'h0000;
        off[1] = applied_q ? dly_rev_q[15:0] : dly_fwd_q[15:0];
        off[2] = applied_q ? dly_rev_q[31:16] : dly_fwd_q[31:16];
        if (mode == MODE_SINGLE) begin
            off[1] = 16'h0000;
            off[2] = 16'h0000;
        end else if (mode == MODE_HDR || mode == MODE_HIGH_WELL) begin
            off[2] = 16'h0000;
        end
    end

    // Per-plane line counters restart when a new direction applies
    for (genvar p = 0; p < 3; p++) begin : g_line
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                line_q[p] <= 16'h0000;
            end else if (apply) begin
                line_q[p] <= (p == 0) ? 16'h0001 : 16'h0000;
            end else if (take && pix_sol && pix_plane == 2'(p)) begin
                line_q[p] <= line_q[p] + 16'h0001;
            end
        end
    end

    // Lines since the last reversal, counting the line now taken
    always_comb begin
        if (apply) begin
            warm_d = 8'h01;
        end else if (sol0 && warm_q < stages_q) begin
            warm_d = warm_q + 8'h01;
        end else begin
            warm_d = warm_q;
        end
    end

    // Line count register, saturating at the stage count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warm_q <= 8'h00;
        end else begin
            warm_q <= warm_d;
        end
    end

    // Stamp: matching lines of every plane carry one value; applying line is line one
    assign stamp = apply ? 16'h0001
        : (pix_sol ? line_q[pix_plane] + 16'h0001 : line_q[pix_plane])
        + off[pix_plane];

    // Marker phases
    assign row_hit = (pix_sol && pix_plane == 2'b00) ? (row_ph_q == 16'h0000) : row_hit_q;
    assign col_ph_cur = pix_sol ? ovl_col_q[31:16] : col_ph_q;
    assign col_hit = (col_ph_cur == 16'h0000);
    assign mark = ctrl_q[`TDSA_CTRL_MARK] & (row_hit | col_hit);

    // Row and column marker counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_ph_q <= 16'h0000;
            row_hit_q <= 1'b0;
            col_ph_q <= 16'h0000;
        end else begin
            if (!ctrl_q[`TDSA_CTRL_MARK] || apply) begin
                row_ph_q <= ovl_row_q[31:16];
                row_hit_q <= 1'b0;
            end else if (sol0) begin
                row_ph_q <= ph_next(row_ph_q, ovl_row_q[15:0]);
                row_hit_q <= (row_ph_q == 16'h0000);
            end
            if (take) begin
                col_ph_q <= ph_next(col_ph_cur, ovl_col_q[15:0]);
            end
        end
    end

    // Overlay value, dark or full scale
    assign val = mark ? (ctrl_q[`TDSA_CTRL_DARK] ? 12'h000 : `TDSA_PIX_MAX) : pix_data;

    // Parallax target from angle sign and mode
    always_comb begin
        if (ctrl_q[`TDSA_CTRL_ANGNEG]) begin
            tgt = 2'b00;
        end else if (mode == MODE_TRIPLE || mode == MODE_SR) begin
            tgt = 2'b10;
        end else begin
            tgt = 2'b01;
        end
    end

    // Stretch: spread full-minus-source duplicates over the source width
    assign sel = ctrl_q[`TDSA_CTRL_PLXON] & (pix_plane == tgt);
    assign acc_cur = pix_sol ? 15'h0000 : acc_q;
    assign acc_sum = acc_cur + (`TDSA_FULL_W - plx_w_q);
    assign need_dup = sel & (acc_sum >= plx_w_q);
    assign acc_d = need_dup ? acc_sum - plx_w_q : acc_sum;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 15'h0000;
        end else if (take && sel) begin
            acc_q <= acc_d;
        end
    end

    // Output word: sol, settled, plane, stamp, pixel
    assign word = {pix_sol, (warm_d >= stages_q), pix_plane, stamp, val};

    // Push stage, repeating a stretched pixel once
    assign dup_d = take ? need_dup : 1'b0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            push_v_q <= 1'b0;
            push_w_q <= 32'h0000_0000;
            dup_q <= 1'b0;
            pix_ready_q <= 1'b0;
        end else begin
            dup_q <= dup_d;
            if (take) begin
                push_v_q <= 1'b1;
                push_w_q <= word;
            end else if (dup_q) begin
                push_v_q <= 1'b1;
                push_w_q[31] <= 1'b0;
            end else begin
                push_v_q <= 1'b0;
            end
            pix_ready_q <= ~dup_d & fifo_in_ready & (level <= 6'd28);
        end
    end

    tdsa_fifo #(
        .W(32),
        .D(32)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(push_v_q),
        .in_ready(fifo_in_ready),
        .in_data(push_w_q),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data),
        .level(level)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pix_ready = pix_ready_q;
    assign scan_dir = dir_q;
    assign switch_busy = busy_q;
endmodule
`default_nettype wire

// *** tb/tdsa_grabber.sv ***
// Frame grabber model taking the output stream with random stalls
`timescale 1ns/100ps
`default_nettype none
module tdsa_grabber (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [31:0] out_data,
    output var logic out_ready
);
    logic [31:0] got_q[$];
    int seed = 75052;
    // Keep every word with its plane field; ready drops at random or on stall
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ready <= 1'b0;
        end else begin
            if (out_valid && out_ready) got_q.push_back(out_data);
            out_ready <= !stall && ($random(seed) % 4 != 0);
        end
    end
endmodule
`default_nettype wire

// *** tb/tdsa_top_sva.sv ***
// Port checker for the scan direction and line alignment block
`timescale 1ns/100ps
`default_nettype none
module tdsa_top_sva #(
    parameter int SWITCH_CYC = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [31:0] out_data,
    input wire logic scan_dir,
    input wire logic switch_busy
);
    logic turned_q;
    logic [31:0] sw_n_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Marks that the direction has already turned in this busy phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) turned_q <= 1'b0;
        else if (!switch_busy) turned_q <= 1'b0;
        else if ($changed(scan_dir)) turned_q <= 1'b1;
    end
    // Cycles spent switching before the direction turns
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sw_n_q <= 32'h0;
        else if (switch_busy && !turned_q) sw_n_q <= sw_n_q + 32'h1;
        else sw_n_q <= 32'h0;
    end
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_ready_wait: assert property (psel && !penable |-> ##2 pready) else $error("pready late");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    a_err_zero: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
    a_switch_bound: assert property (sw_n_q <= SWITCH_CYC + 2) else $error("switch slow");
    a_switch_min: assert property ($rose(switch_busy) |=> $stable(scan_dir) [*8])
        else $error("turned early");
    a_dir_busy: assert property ($changed(scan_dir) |-> $past(switch_busy) && switch_busy)
        else $error("turn outside switch");
    a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output dropped");
    c_err: cover property (pslverr);
    c_switch: cover property ($rose(switch_busy));
    c_line: cover property (out_valid && out_ready && out_data[31]);
endmodule
bind tdsa_top tdsa_top_sva #(.SWITCH_CYC(SWITCH_CYC)) u_tdsa_top_sva (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .scan_dir(scan_dir), .switch_busy(switch_busy));
`default_nettype wire

// *** tb/tdsa_top_test.sv ***
// Bench: registers, direction turns, alignment stamps, markers, FIFO fill
`timescale 1ns/100ps
`default_nettype none
module tdsa_top_test;
    import tdsa_pkg::*;
    localparam int SW = 20;
    localparam int PLW = 5462;
    logic pclk, presetn, psel, penable, pwrite, gpio_dir_line, enc_dir_motion, err;
    logic pix_valid, pix_sol, stall, full_seen, pready, pslverr, pix_ready, out_valid;
    logic out_ready, scan_dir, switch_busy, dir_m, pend, want;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, out_data, rd;
    logic [1:0] pix_plane;
    logic [11:0] pix_data;
    logic [31:0] exp_q[$];
    logic [7:0] ra[8] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h30};
    logic [31:0] rv[8] = '{0, 32'h40, 32'h40, 32'h014600a3, 32'h00c60063, 32'h80, 32'h2000, 0};
    logic [31:0] tc[3] = '{32'h14, 32'h11, 32'h12};
    int n_fail = 0, num_checks = 0, seed = 75052, mode, mrk;
    int cnt[3], dly[2], dl2[2], wm, rh, acc, plx_t = -1;
    tdsa_top #(.SWITCH_CYC(SW)) u_tdsa_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gpio_dir_line(gpio_dir_line),
        .enc_dir_motion(enc_dir_motion), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .pix_sol(pix_sol), .pix_plane(pix_plane), .pix_data(pix_data), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .scan_dir(scan_dir),
        .switch_busy(switch_busy));
    tdsa_grabber u_tdsa_grabber (.clk(pclk), .rst_n(presetn), .stall(stall),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
    // Clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Notes a refusal while the grabber stalls
    always @(posedge pclk) full_seen <= presetn && (full_seen || (stall && !pix_ready));
    task automatic final_report;
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tmo;
        n_fail++;
        final_report();
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One APB transfer, released only after pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        k = 0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) tmo();
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk(err, a == 8'h30);
    endtask
    // One pixel; the model works out the word the grabber should get
    task automatic pix(input logic [1:0] pl, input int i);
        int k;
        logic [11:0] v;
        logic [15:0] st;
        logic [31:0] w;
        logic dup;
        v = 12'($random(seed));
        pix_valid <= 1'b1;
        pix_sol <= (i == 0);
        pix_plane <= pl;
        pix_data <= v;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pix_ready !== 1'b1 && k < 500);
        if (k >= 500) tmo();
        if (i == 0 && pl == 2'h0 && pend) begin
            cnt = '{1, 0, 0};
            dir_m = want;
            pend = 1'b0;
            wm = 1;
        end else if (i == 0) begin
            cnt[pl]++;
            // Row pitch one: every main line is a marker row while markers are on
            if (pl == 2'h0) rh = mrk;
            if (pl == 2'h0 && wm < 2) wm++;
        end
        st = 16'(cnt[pl] + ((mode != 0 && pl == 2'h1) ? dly[dir_m] : 0)
            + ((mode >= 3 && pl == 2'h2) ? dl2[dir_m] : 0));
        if (mrk != 0 && (i % 4 == 0 || rh != 0)) v = 12'h000;
        // Stretch of the chosen plane, one duplicate when the spread owes a pixel
        dup = 1'b0;
        if (pl == plx_t) begin
            acc = (i == 0 ? 0 : acc) + 8192 - PLW;
            dup = (acc >= PLW);
            if (dup) acc -= PLW;
        end
        w = {i == 0, wm >= 2, pl, st, v};
        exp_q.push_back(w);
        if (dup) exp_q.push_back({1'b0, w[30:0]});
    endtask
    task automatic line(input logic [1:0] pl, input int n);
        for (int i = 0; i < n; i++) pix(pl, i);
        pix_valid <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic drain;
        int k;
        k = 0;
        while (u_tdsa_grabber.got_q.size() < exp_q.size() && k < 2000) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 2000) tmo();
        while (exp_q.size() > 0) chk(u_tdsa_grabber.got_q.pop_front(),
            exp_q.pop_front());
    endtask
    // Direction turn, then the applying line and a secondary line
    task automatic turn(input logic [31:0] c, input logic w);
        int k;
        apb(1'b1, 8'h00, c);
        k = 0;
        while (scan_dir !== w && k < 200) begin
            @(posedge pclk);
            k++;
        end
        chk(scan_dir, w);
        pend = 1'b1;
        want = w;
        line(2'h0, 4);
        chk(switch_busy, 1'b0);
        line(2'h1, 4);
        drain();
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pix_valid, pix_sol, pix_plane, pix_data} = '0;
        {gpio_dir_line, stall, presetn, pend, dir_m, want, mode, mrk} = '0;
        enc_dir_motion = 1'b1;
        cnt = '{0, 0, 0};
        dly = '{163, 99};
        dl2 = '{326, 198};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[j]) rdchk(ra[j], rv[j]);
        apb(1'b1, 8'h18, 32'h0);
        rdchk(8'h18, 32'h80);
        apb(1'b1, 8'h18, 32'h2);
        rdchk(8'h18, 32'h2);
        mode = 1;
        apb(1'b1, 8'h00, {25'h0, MODE_HDR, 4'h0});
        repeat (2) begin
            line(2'h0, 4);
            line(2'h1, 4);
        end
        drain();
        foreach (tc[j]) turn(tc[j], j != 1);
        mode = 0;
        mrk = 1;
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h0c, 32'h4);
        apb(1'b1, 8'h00, 32'h302);
        line(2'h1, 8);
        line(2'h0, 8);
        line(2'h1, 8);
        drain();
        mrk = 0;
        apb(1'b1, 8'h00, 32'h2);
        stall <= 1'b1;
        fork
            begin
                repeat (80) @(posedge pclk);
                stall <= 1'b0;
            end
        join_none
        line(2'h0, 40);
        drain();
        chk(full_seen, 1'b1);
        apb(1'b1, 8'h1c, PLW);
        for (int j = 0; j < 2; j++) begin
            mode = (j != 0) ? 1 : 4;
            plx_t = (j != 0) ? 0 : 2;
            apb(1'b1, 8'h00, (j != 0) ? 32'hc12 : 32'h842);
            for (int p = 0; p < 3; p++) line(2'(p), 6);
        end
        drain();
        rdchk(8'h04, 32'h3);
        rdchk(8'h20, {8'h00, 8'(wm), 16'(cnt[0])});
        final_report();
    end
endmodule
`default_nettype wire
